// ### logic/ppr_pkg.sv
package ppr_pkg;
  // remappable pin count and peripheral slot counts
  localparam int NUM_PINS = 8;
  localparam int NUM_INS = 8;
  localparam int SEL_W = 4;
  localparam logic [3:0] SEL_NONE = 4'h0;
  localparam logic [3:0] SEL_RESET = 4'h0;
  localparam logic LOCK_RESET = 1'b0;
endpackage

// ### logic/ppr_remap.sv
`timescale 1ns/100ps
module ppr_remap (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // selector programming port
  input wire logic in_sel_we_in,
  input wire logic [2:0] in_sel_idx_in,
  input wire logic [3:0] in_sel_data_in,
  input wire logic out_sel_we_in,
  input wire logic [2:0] out_sel_idx_in,
  input wire logic [3:0] out_sel_data_in,
  input wire logic lock_set_in,
  input wire logic lock_clr_in,
  output logic lock_out,
  output logic [31:0] in_sel_flat_out,
  output logic [31:0] out_sel_flat_out,
  // remappable peripheral side (slot 0 is uart_one_receive_input)
  input wire logic [14:0] periph_out_in,
  input wire logic [14:0] periph_oe_in,
  output logic [7:0] periph_in_out,
  // fixed function and analog claims per pin
  input wire logic [7:0] fixed_do_in,
  input wire logic [7:0] fixed_oe_in,
  input wire logic [7:0] analog_en_in,
  // pad side, pin index = remappable_pin_index
  input wire logic [7:0] pad_in,
  output logic [7:0] pad_do_out,
  output logic [7:0] pad_oe_n_out
);
  logic [3:0] in_sel_r [ppr_pkg::NUM_INS];
  logic [3:0] in_sel_nxt [ppr_pkg::NUM_INS];
  logic [3:0] out_sel_r [ppr_pkg::NUM_PINS];
  logic [3:0] out_sel_nxt [ppr_pkg::NUM_PINS];
  logic lock_r;
  logic lock_nxt;

  // lock and selector next state; lock guards against runaway writes
  always_comb begin
    lock_nxt = lock_r;
    if (lock_set_in) begin
      lock_nxt = 1'b1;
    end else if (lock_clr_in) begin
      lock_nxt = 1'b0;
    end
    for (int i = 0; i < ppr_pkg::NUM_INS; i++) begin
      in_sel_nxt[i] = in_sel_r[i];
    end
    for (int i = 0; i < ppr_pkg::NUM_PINS; i++) begin
      out_sel_nxt[i] = out_sel_r[i];
    end
    if (in_sel_we_in && !lock_r) begin
      in_sel_nxt[in_sel_idx_in] = in_sel_data_in;
    end
    if (out_sel_we_in && !lock_r) begin
      out_sel_nxt[out_sel_idx_in] = out_sel_data_in;
    end
  end

  // selector registers
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      lock_r <= ppr_pkg::LOCK_RESET;
      for (int i = 0; i < ppr_pkg::NUM_INS; i++) begin
        in_sel_r[i] <= ppr_pkg::SEL_RESET;
      end
      for (int i = 0; i < ppr_pkg::NUM_PINS; i++) begin
        out_sel_r[i] <= ppr_pkg::SEL_RESET;
      end
    end else begin
      lock_r <= lock_nxt;
      in_sel_r <= in_sel_nxt;
      out_sel_r <= out_sel_nxt;
    end
  end

  assign lock_out = lock_r;

  genvar g;
  generate
    // output side, one slice a pin; the selector picks a peripheral source
    for (g = 0; g < ppr_pkg::NUM_PINS; g++) begin : g_pin
      logic [3:0] os;
      logic rm_act;
      assign os = out_sel_r[g];
      // unmapped peripherals reach no pin
      // code k+1 picks source k, so code 0 never reaches a source
      assign rm_act = (os != ppr_pkg::SEL_NONE) && periph_oe_in[os - 4'h1];
      assign pad_oe_n_out[g] = analog_en_in[g] ? 1'b1 :
                               rm_act ? 1'b0 : !fixed_oe_in[g];
      assign pad_do_out[g] = (rm_act && !analog_en_in[g]) ?
                             periph_out_in[os - 4'h1] : fixed_do_in[g];
      assign out_sel_flat_out[g*4 +: 4] = out_sel_r[g];
      // an analog pin must never see a digital driver, mapped or not
      chk_analog_each: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        analog_en_in[g] |-> pad_oe_n_out[g])
        else $error("pad driven over analog");
      // an unmapped digital pin belongs wholly to its fixed function
      chk_fixed_owner: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        out_sel_r[g] == ppr_pkg::SEL_NONE && !analog_en_in[g] |->
        pad_oe_n_out[g] == !fixed_oe_in[g] && pad_do_out[g] == fixed_do_in[g])
        else $error("unmapped pin not with fixed function");
    end
    // input side, one slice a peripheral input; the selector picks a pin
    for (g = 0; g < ppr_pkg::NUM_INS; g++) begin : g_in
      logic [3:0] is;
      assign is = in_sel_r[g];
      // codes past pin subset read low
      // dedicated and analog modules bypass
      // analog on the pin masks the digital input, so no half-level reaches a slot
      assign periph_in_out[g] = (is != ppr_pkg::SEL_NONE) && (int'(is) <= ppr_pkg::NUM_PINS) &&
                                !analog_en_in[3'(is - 4'h1)] && pad_in[3'(is - 4'h1)];
      assign in_sel_flat_out[g*4 +: 4] = in_sel_r[g];
      // a slot with no code samples nothing, whatever the pads do
      chk_slot_idle: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        in_sel_r[g] == ppr_pkg::SEL_NONE |-> !periph_in_out[g])
        else $error("unmapped input slot connected");
    end
  endgenerate

  // lock checks; lock_out is registered, so every effect shows one edge late
  chk_lock_blocks: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    lock_r && !lock_clr_in |=> $stable(out_sel_flat_out) && $stable(in_sel_flat_out))
    else $error("selector changed while locked");
  chk_lock_sets: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    lock_set_in |=> lock_out)
    else $error("lock did not set");
  // set beats clear, so a stray clear cannot open a lock being closed
  chk_set_wins: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    lock_set_in && lock_clr_in |=> lock_out)
    else $error("clear beat set on lock");
  chk_lock_clears: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    !lock_set_in && lock_clr_in |=> !lock_out)
    else $error("lock did not clear");
  chk_lock_holds: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    !lock_set_in && !lock_clr_in |=> $stable(lock_out))
    else $error("lock changed without request");
  chk_locked_out: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    lock_r && out_sel_we_in |=> $stable(out_sel_flat_out))
    else $error("output selector written while locked");

  // selector checks; a write shows on the flat outputs one edge after it is taken
  chk_write_lands: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    in_sel_we_in && !lock_r && in_sel_idx_in == 3'h0 |=>
    in_sel_flat_out[3:0] == $past(in_sel_data_in))
    else $error("input selector write lost");
  chk_out_lands: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    out_sel_we_in && !lock_r && out_sel_idx_in == 3'h0 |=>
    out_sel_flat_out[3:0] == $past(out_sel_data_in))
    else $error("output selector write lost");
  // the two selector sets never disturb each other
  chk_in_keeps_out: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    in_sel_we_in && !out_sel_we_in |=> $stable(out_sel_flat_out))
    else $error("input write moved output selectors");
  chk_out_keeps_in: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    out_sel_we_in && !in_sel_we_in |=> $stable(in_sel_flat_out))
    else $error("output write moved input selectors");
  chk_slot_kept: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    in_sel_we_in && in_sel_idx_in != 3'h0 |=> $stable(in_sel_flat_out[3:0]))
    else $error("write to another slot moved slot zero");
  // reset checks carry no disable, since they watch reset itself
  chk_reset_zero: assert property (@(posedge core_clk_in)
    !rst_n_in |=> out_sel_flat_out == 32'h0 && in_sel_flat_out == 32'h0)
    else $error("selectors not zero after reset");
  chk_reset_lock: assert property (@(posedge core_clk_in)
    !rst_n_in |=> !lock_out)
    else $error("lock not clear after reset");

  // pad and input path checks on pins 0 to 2 and input slot 0
  chk_analog_wins: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    analog_en_in[0] |-> pad_oe_n_out[0])
    else $error("pin driven over analog");
  chk_unmapped_idle: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    out_sel_flat_out[3:0] == 4'h0 |-> pad_oe_n_out[0] == !fixed_oe_in[0] || analog_en_in[0])
    else $error("unmapped pin not fixed");
  chk_in_unmapped: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    in_sel_flat_out[3:0] == 4'h0 |-> !periph_in_out[0])
    else $error("unmapped input connected");
  chk_remap_drive: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    out_sel_flat_out[3:0] == 4'h1 && periph_oe_in[0] && !analog_en_in[0] |->
    !pad_oe_n_out[0] && pad_do_out[0] == periph_out_in[0])
    else $error("remap not driving pin");
  chk_pin1_drive: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    out_sel_flat_out[7:4] == 4'h5 && periph_oe_in[4] && !analog_en_in[1] |->
    !pad_oe_n_out[1] && pad_do_out[1] == periph_out_in[4])
    else $error("remap not driving pin one");
  chk_in_follows: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    in_sel_flat_out[3:0] == 4'h3 && !analog_en_in[2] |-> periph_in_out[0] == pad_in[2])
    else $error("input slot not following its pin");
  chk_in_analog: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    in_sel_flat_out[3:0] == 4'h3 && analog_en_in[2] |-> !periph_in_out[0])
    else $error("analog pin reached input slot");
endmodule

// ### verif/ppr_pad_model.sv
`timescale 1ns/100ps
module ppr_pad_model (
  // pad ring, one bit a pin
  input wire logic [7:0] pad_do_in,
  input wire logic [7:0] pad_oe_n_in,
  input wire logic [7:0] ext_in,
  output logic [7:0] pad_out
);
  // wire level
  // a pad reads back its own drive, else the outside level
  assign pad_out = (pad_do_in & ~pad_oe_n_in) | (ext_in & pad_oe_n_in);
endmodule

// ### verif/testbench.sv
`timescale 1ns/100ps
`define CHK(nm, e, s) begin n_compared++; if ((e) !== (s)) begin n_mismatch++; \
  $display("Error %s exp %h got %h", nm, e, s); end end
module testbench;
  logic core_clk_in = 0, rst_n_in = 0, iwe = 0, owe = 0, lset = 0, lclr = 0, lock;
  logic [2:0] iidx = 0, oidx = 0;
  logic [3:0] idat = 0, odat = 0;
  logic [14:0] pout = 0, poe = 0;
  logic [7:0] fdo = 0, foe = 0, ana = 0, ext = 0, pin, pdo, poen, pin_o;
  logic [31:0] iflat, oflat;
  int n_mismatch = 0, n_compared = 0;
  // free running clock
  always #10 core_clk_in = ~core_clk_in;
  ppr_remap i_ppr_remap (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
    .in_sel_we_in(iwe), .in_sel_idx_in(iidx), .in_sel_data_in(idat), .out_sel_we_in(owe),
    .out_sel_idx_in(oidx), .out_sel_data_in(odat), .lock_set_in(lset), .lock_clr_in(lclr),
    .lock_out(lock), .in_sel_flat_out(iflat), .out_sel_flat_out(oflat), .periph_out_in(pout),
    .periph_oe_in(poe), .periph_in_out(pin_o), .fixed_do_in(fdo), .fixed_oe_in(foe),
    .analog_en_in(ana), .pad_in(pin), .pad_do_out(pdo), .pad_oe_n_out(poen));
  ppr_pad_model i_ppr_pad_model (.pad_do_in(pdo), .pad_oe_n_in(poen), .ext_in(ext),
    .pad_out(pin));
  task automatic finish_test;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // one selector write, taken at the rising edge between two falls
  task automatic wr(input logic i, input logic [2:0] x, input logic [3:0] d);
    @(negedge core_clk_in);
    if (i) begin
      iwe = 1;
      iidx = x;
      idat = d;
    end else begin
      owe = 1;
      oidx = x;
      odat = d;
    end
    @(negedge core_clk_in);
    iwe = 0;
    owe = 0;
  endtask
  task automatic t_reset;
    fdo = 8'h5a;
    foe = 8'h0f;
    ext = 8'hff;
    #1;
    `CHK("lock", 1'b0, lock)
    `CHK("iflat", 32'h0, iflat)
    `CHK("oflat", 32'h0, oflat)
    `CHK("pin_o", 8'h00, pin_o)
    `CHK("poen", 8'hf0, poen)
    `CHK("pdo", 8'h0a, pdo & foe)
  endtask
  // fixed drivers off, so the sampled pins show the outside level
  task automatic t_in;
    @(negedge core_clk_in);
    foe = 8'h00;
    wr(1, 3'h0, 4'h3); // valid code
    `CHK("iflat", 4'h3, iflat[3:0])
    `CHK("slot0", 1'b1, pin_o[0])
    ext = 8'hfb;
    #1;
    `CHK("slot0", 1'b0, pin_o[0])
    @(negedge core_clk_in);
    ext = 8'hff;
    ana = 8'h04;
    #1;
    `CHK("slot0", 1'b0, pin_o[0])
    wr(1, 3'h1, 4'h8); // valid code
    `CHK("slot1", 1'b1, pin_o[1])
    wr(1, 3'h1, 4'h0);
    `CHK("slot1", 1'b0, pin_o[1])
  endtask
  task automatic t_out;
    @(negedge core_clk_in);
    pout = 15'h0011;
    poe = 15'h0011;
    fdo = 8'h00;
    foe = 8'h02;
    wr(0, 3'h1, 4'h5);
    `CHK("oflat", 4'h5, oflat[7:4])
    `CHK("pdo1", 1'b1, pdo[1])
    `CHK("poen1", 1'b0, poen[1])
    `CHK("slot0", 1'b0, pin_o[0])
    `CHK("iflat", 4'h3, iflat[3:0])
    wr(0, 3'h0, 4'h1);
    `CHK("pdo0", 1'b1, pdo[0])
    `CHK("poen0", 1'b0, poen[0])
    foe = 8'h00;
    ana = 8'h03;
    #1;
    `CHK("poen1", 1'b1, poen[1])
    `CHK("poen0", 1'b1, poen[0])
  endtask
  // set and clear together first: the set must win
  task automatic t_lock;
    @(negedge core_clk_in);
    lset = 1;
    lclr = 1;
    @(negedge core_clk_in);
    lset = 0;
    lclr = 0;
    `CHK("lock", 1'b1, lock)
    wr(1, 3'h0, 4'h7);
    `CHK("lock", 1'b1, lock)
    `CHK("iflat", 4'h3, iflat[3:0])
    wr(0, 3'h0, 4'h0);
    `CHK("oflat", 4'h1, oflat[3:0])
    lclr = 1;
    @(negedge core_clk_in);
    lclr = 0;
    wr(1, 3'h0, 4'h7);
    `CHK("iflat", 4'h7, iflat[3:0])
  endtask
  // reset in mid-run drops the lock and every mapping
  task automatic t_rerun;
    lset = 1;
    @(negedge core_clk_in);
    lset = 0;
    `CHK("lock", 1'b1, lock)
    rst_n_in = 0;
    @(negedge core_clk_in);
    rst_n_in = 1;
    #1;
    `CHK("lock", 1'b0, lock)
    `CHK("iflat", 32'h0, iflat)
    `CHK("oflat", 32'h0, oflat)
    `CHK("pin_o", 8'h00, pin_o)
    `CHK("poen", 8'hff, poen)
    wr(1, 3'h0, 4'h3); // valid code
    `CHK("iflat", 4'h3, iflat[3:0])
    `CHK("slot0", 1'b1, pin_o[0])
  endtask
  // watchdog at 5000 cycles, far beyond the 50 or so cycles needed
  initial begin
    #100000;
    n_mismatch++;
    finish_test;
  end
  // main sequence after 20 cycles of reset
  initial begin
    repeat (20) @(negedge core_clk_in);
    rst_n_in = 1;
    t_reset;
    t_in;
    t_out;
    t_lock;
    t_rerun;
    finish_test;
  end
endmodule
